/* rtl/ams_pkg.sv */
// constants, layouts and types of the auto/manual remote/local selector
// Function
// - assigned A/M contact open holds manual and blocks A/M key requests
// - handover setting picks bumpless transfer or previously held manual level
// - bumpless entry to manual starts from last automatic output level
// - return to auto starts PID from the manual output level
// - A/M screen: UP selects manual and lights lamp, DOWN selects auto
// - each A/M toggle key press inverts the A/M request
// - assigned contact closed requests auto, open requests manual
// - contact change takes effect 200 ms plus one sampling cycle later
// - sampling cycle is a setting, default 100 ms
// - auto only if key/comm and contact both auto; lamp marks manual
// - in manual UP raises and DOWN lowers the output level
// - holding UP or DOWN speeds up the level change
// - position control with valve feedback: keys set valve target
// - no feedback: drives follow held keys, lamps follow, level hidden
// - assigned R/L contact open holds local and blocks R/L key requests
// - R/L screen: UP selects remote and lights lamp, DOWN selects local
// - remote lamp stays dark in stop mode
// - with key type 2 each R/L toggle press inverts R/L request
// - assigned contact closed requests remote, open requests local
// - remote only if key/comm and contact both remote; lamp marks it
// - direct key type defaults to type 1
package ams_pkg;
   localparam int CLK_KHZ     = 20000;
   localparam int TICK_MS     = 1;
   localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
   localparam logic [15:0] HOLD_MS     = 16'h07D0;
   localparam logic [15:0] CONTACT_MS  = 16'h00C8;
   localparam logic [15:0] SAMPLE_MS   = 16'h0064;
   localparam logic [15:0] REPEAT_MS   = 16'h0064;
   localparam logic [15:0] ACCEL_MS    = 16'h03E8;
   localparam logic [15:0] LEVEL_MAX   = 16'h03E8;
   localparam logic [15:0] STEP_SLOW   = 16'h0001;
   localparam logic [15:0] STEP_FAST   = 16'h000A;
   localparam logic [11:0] OFF_CTRL    = 12'h000;
   localparam logic [11:0] OFF_SAMPLE  = 12'h004;
   localparam logic [11:0] OFF_STATUS  = 12'h008;
   localparam logic [11:0] OFF_LEVEL   = 12'h00C;
   localparam int KEY_UP = 0;
   localparam int KEY_DN = 1;
   localparam int KEY_SH = 2;
   localparam int KEY_AM = 3;
   localparam int KEY_RL = 4;
   localparam logic [1:0] ASG_NONE  = 2'h0;
   localparam logic [1:0] ASG_FIVE  = 2'h1;
   localparam logic [1:0] ASG_SIX   = 2'h2;
   localparam logic [1:0] ASG_SEVEN = 2'h3;

   typedef struct packed {
      logic [1:0] rlAssign;
      logic [1:0] amAssign;
      logic       stopMode;
      logic       posProp;
      logic       fbrFitted;
      logic       keyType2;
      logic       bumpless;
      logic       reqRemote;
      logic       reqAuto;
   } ams_ctrl_t;
   localparam int CTRL_W = $bits(ams_ctrl_t);
   localparam logic [10:0] CTRL_RST = 11'h005;

   typedef struct packed {
      logic [2:0] contacts;
      logic       menuOpen;
      logic       rlLocked;
      logic       amLocked;
      logic       levelHide;
      logic       remoteLamp;
      logic       manualLamp;
      logic       remoteEff;
      logic       autoEff;
   } ams_status_t;
   localparam int STAT_W = $bits(ams_status_t);

   typedef enum logic [1:0] {SCR_MONITOR, SCR_AM, SCR_RL} ams_screen_t;
endpackage

/* rtl/ams_mode_select.sv */
// auto/manual and remote/local mode resolution with APB registers
`timescale 1ns/1ps
module ams_mode_select #(
   parameter int TICK_CYCLES = ams_pkg::TICK_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        keyUp,
   input  wire logic        keyDown,
   input  wire logic        keyShift,
   input  wire logic        keyAmToggle,
   input  wire logic        keyRlToggle,
   input  wire logic        contactInputFive,
   input  wire logic        contactInputSix,
   input  wire logic        contactInputSeven,
   input  wire logic [15:0] autoLevel,
   output      logic [15:0] controlOutputLevel,
   output      logic [15:0] pidStartLevel,
   output      logic        pidLoad,
   output      logic [15:0] valveTargetLevel,
   output      logic        openSideDrive,
   output      logic        closeSideDrive,
   output      logic        openSideLamp,
   output      logic        closeSideLamp,
   output      logic        levelDisplayHide,
   output      logic        handOperationLamp,
   output      logic        farSourceLamp
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   function automatic logic pickContact(input logic [1:0] asg,
                                        input logic [2:0] c);
      logic r;
      r = 1'b1;
      unique case (asg)
         ams_pkg::ASG_FIVE:  r = c[0];
         ams_pkg::ASG_SIX:   r = c[1];
         ams_pkg::ASG_SEVEN: r = c[2];
         ams_pkg::ASG_NONE:  r = 1'b1;
      endcase
      return r;
   endfunction

   ams_pkg::ams_ctrl_t   ctrl_q;
   ams_pkg::ams_screen_t screen_q, screen_d;
   logic [TW-1:0] msCnt_q;
   logic [15:0]   smpMs_q, smpCnt_q, shiftMs_q, holdMs_q, repMs_q;
   logic [15:0]   manual_q, level_q, valve_q, pidStart_q;
   logic [2:0]    sync1_q, sync2_q, smp_q;
   logic [4:0]    keyPrev_q;
   logic [1:0]    contEff;
   logic [31:0]   rdata_q;
   logic          err_q, autoPrev_q, pidLoad_q, menu_q;
   logic          openDrv_q, closeDrv_q, hide_q, manLamp_q, remLamp_q;

   // timing ticks
   wire msTick = msCnt_q == TW'(TICK_CYCLES - 1);
   // >= so a shorter cycle written mid-count wraps at once
   wire smpEnd = (smpMs_q <= 16'h0001) ||
                 (smpCnt_q >= smpMs_q - 16'h0001);
   wire sampleTick = msTick & smpEnd;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         msCnt_q  <= '0;
         smpCnt_q <= '0;
      end else begin
         msCnt_q <= msTick ? '0 : msCnt_q + TW'(1);
         if (msTick) begin
            smpCnt_q <= smpEnd ? '0 : smpCnt_q + 16'h0001;
         end
      end
   end

   // contacts: two-stage sync, then one sample per cycle
   wire [2:0] contactRaw = {contactInputSeven, contactInputSix,
                            contactInputFive};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '1;
         sync2_q <= '1;
         smp_q   <= '1;
      end else begin
         sync1_q <= contactRaw;
         sync2_q <= sync1_q;
         if (sampleTick) begin
            smp_q <= sync2_q;
         end
      end
   end

   // per function delay filter: 0 is auto/manual, 1 is remote/local
   wire [1:0] asgSel [2];
   assign asgSel[0] = ctrl_q.amAssign;
   assign asgSel[1] = ctrl_q.rlAssign;

   for (genvar i = 0; i < 2; i++) begin : g_flt
      logic        pend_q, eff_q;
      logic [15:0] cnt_q;
      // closed asks auto/remote, open asks manual/local
      wire sel = pickContact(asgSel[i], smp_q);
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            pend_q <= 1'b1;
            eff_q  <= 1'b1;
            cnt_q  <= '0;
         end else if (sel != pend_q) begin
            pend_q <= sel;
            cnt_q  <= ams_pkg::CONTACT_MS;
         end else if (cnt_q != 16'h0000) begin
            if (msTick) begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end else if (sampleTick) begin
            eff_q <= pend_q;
         end
      end
      assign contEff[i] = eff_q;
   end

   // mode resolution
   wire autoEff   = ctrl_q.reqAuto & contEff[0];
   wire remoteEff = ctrl_q.reqRemote & contEff[1];
   wire amLocked  = !contEff[0];
   wire rlLocked  = !contEff[1];

   // keys
   wire [4:0] keys  = {keyRlToggle, keyAmToggle, keyShift, keyDown, keyUp};
   wire [4:0] press = keys & ~keyPrev_q;
   wire amScr = screen_q == ams_pkg::SCR_AM;
   wire rlScr = screen_q == ams_pkg::SCR_RL;
   wire monScr = screen_q == ams_pkg::SCR_MONITOR;
   wire amTgl = press[ams_pkg::KEY_AM];
   wire rlTgl = press[ams_pkg::KEY_RL] & ctrl_q.keyType2;
   wire amToMan = !amLocked & ((amScr & press[ams_pkg::KEY_UP]) |
                               (amTgl & ctrl_q.reqAuto));
   wire amToAuto = !amLocked & ((amScr & press[ams_pkg::KEY_DN]) |
                                (amTgl & !ctrl_q.reqAuto));
   wire rlToRem = !rlLocked & ((rlScr & press[ams_pkg::KEY_UP]) |
                               (rlTgl & !ctrl_q.reqRemote));
   wire rlToLoc = !rlLocked & ((rlScr & press[ams_pkg::KEY_DN]) |
                               (rlTgl & ctrl_q.reqRemote));

   // menu entry after a long shift hold
   wire holdDone = keys[ams_pkg::KEY_SH] & msTick &
                   (shiftMs_q == ams_pkg::HOLD_MS - 16'h0001);
   always_comb begin
      screen_d = screen_q;
      if (holdDone) begin
         screen_d = monScr ? ams_pkg::SCR_AM : ams_pkg::SCR_MONITOR;
      end else if (press[ams_pkg::KEY_SH]) begin
         unique case (screen_q)
            ams_pkg::SCR_AM:      screen_d = ams_pkg::SCR_RL;
            ams_pkg::SCR_RL:      screen_d = ams_pkg::SCR_AM;
            ams_pkg::SCR_MONITOR: screen_d = ams_pkg::SCR_MONITOR;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         keyPrev_q <= '0;
         shiftMs_q <= '0;
         screen_q  <= ams_pkg::SCR_MONITOR;
      end else begin
         keyPrev_q <= keys;
         screen_q  <= screen_d;
         if (!keys[ams_pkg::KEY_SH]) begin
            shiftMs_q <= '0;
         end else if (msTick && shiftMs_q != ams_pkg::HOLD_MS) begin
            shiftMs_q <= shiftMs_q + 16'h0001;
         end
      end
   end

   // APB decode
   wire setup  = psel & !penable;
   wire access = psel & penable;
   wire hitCtrl = paddr == ams_pkg::OFF_CTRL;
   wire hitSmp  = paddr == ams_pkg::OFF_SAMPLE;
   wire hitStat = paddr == ams_pkg::OFF_STATUS;
   wire hitLvl  = paddr == ams_pkg::OFF_LEVEL;
   wire mapped  = hitCtrl | hitSmp | hitStat | hitLvl;
   wire wrCtrl  = access & pwrite & hitCtrl;
   wire wrSmp   = access & pwrite & hitSmp;

   ams_pkg::ams_status_t status;
   assign status = '{contacts: smp_q, menuOpen: !monScr,
                     rlLocked: rlLocked, amLocked: amLocked,
                     levelHide: hide_q, remoteLamp: remLamp_q,
                     manualLamp: manLamp_q, remoteEff: remoteEff,
                     autoEff: autoEff};

   wire [31:0] rmux =
      hitCtrl ? {{(32 - ams_pkg::CTRL_W){1'b0}}, ctrl_q} :
      hitSmp  ? {16'h0000, smpMs_q} :
      hitStat ? {{(32 - ams_pkg::STAT_W){1'b0}}, status} :
      hitLvl  ? {manual_q, level_q} : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
         err_q   <= 1'b0;
         smpMs_q <= ams_pkg::SAMPLE_MS;
      end else begin
         if (setup) begin
            rdata_q <= rmux;
            err_q   <= !mapped;
         end
         if (wrSmp) begin
            smpMs_q <= pwdata[15:0];
         end
      end
   end
   assign prdata  = rdata_q;
   assign pready  = 1'b1;
   assign pslverr = err_q & access;

   // control register: a bus write wins, keys act only in cycles without one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= ams_pkg::CTRL_RST;
      end else if (wrCtrl) begin
         ctrl_q <= ams_pkg::ams_ctrl_t'(pwdata[ams_pkg::CTRL_W-1:0]);
      end else begin
         if (amToMan) begin
            ctrl_q.reqAuto <= 1'b0;
         end else if (amToAuto) begin
            ctrl_q.reqAuto <= 1'b1;
         end
         if (rlToRem) begin
            ctrl_q.reqRemote <= 1'b1;
         end else if (rlToLoc) begin
            ctrl_q.reqRemote <= 1'b0;
         end
      end
   end

   // manual level adjust with repeat and acceleration
   wire noFbr  = ctrl_q.posProp & !ctrl_q.fbrFitted;
   wire adjOk  = !autoEff & monScr & !noFbr;
   wire held   = keys[ams_pkg::KEY_UP] ^ keys[ams_pkg::KEY_DN];
   wire repHit = held & msTick &
                 (repMs_q == ams_pkg::REPEAT_MS - 16'h0001);
   wire stepEv = (press[ams_pkg::KEY_UP] | press[ams_pkg::KEY_DN] |
                  repHit) & held;
   wire [15:0] step = (holdMs_q >= ams_pkg::ACCEL_MS) ?
                      ams_pkg::STEP_FAST : ams_pkg::STEP_SLOW;
   wire [15:0] upLvl = (manual_q >= ams_pkg::LEVEL_MAX - step) ?
                       ams_pkg::LEVEL_MAX : manual_q + step;
   wire [15:0] dnLvl = (manual_q >= step) ? manual_q - step : '0;
   wire enterMan = autoPrev_q & !autoEff;
   wire leaveMan = !autoPrev_q & autoEff;
   // bumpless entry shows the auto level at once, not the stale one
   wire [15:0] manSrc = (enterMan & ctrl_q.bumpless) ?
                        autoLevel : manual_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdMs_q <= '0;
         repMs_q  <= '0;
      end else if (!held) begin
         holdMs_q <= '0;
         repMs_q  <= '0;
      end else if (msTick) begin
         if (holdMs_q != ams_pkg::ACCEL_MS) begin
            holdMs_q <= holdMs_q + 16'h0001;
         end
         repMs_q <= repHit ? '0 : repMs_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_q <= '0;
      end else if (enterMan) begin
         if (ctrl_q.bumpless) begin
            manual_q <= autoLevel;
         end
      end else if (adjOk && stepEv) begin
         manual_q <= keys[ams_pkg::KEY_UP] ? upLvl : dnLvl;
      end
   end

   // outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         autoPrev_q <= 1'b1;
         pidLoad_q  <= 1'b0;
         pidStart_q <= '0;
         level_q    <= '0;
         valve_q    <= '0;
         openDrv_q  <= 1'b0;
         closeDrv_q <= 1'b0;
         hide_q     <= 1'b0;
         manLamp_q  <= 1'b0;
         remLamp_q  <= 1'b0;
      end else begin
         autoPrev_q <= autoEff;
         pidLoad_q  <= leaveMan;
         if (leaveMan) begin
            pidStart_q <= manual_q;
         end
         level_q <= autoEff ? autoLevel : manSrc;
         valve_q <= (ctrl_q.posProp & ctrl_q.fbrFitted) ?
                    (autoEff ? autoLevel : manSrc) : '0;
         openDrv_q  <= !autoEff & noFbr & monScr &
                       keys[ams_pkg::KEY_UP] & !keys[ams_pkg::KEY_DN];
         closeDrv_q <= !autoEff & noFbr & monScr &
                       keys[ams_pkg::KEY_DN] & !keys[ams_pkg::KEY_UP];
         hide_q     <= !autoEff & noFbr;
         manLamp_q  <= !autoEff;
         remLamp_q  <= remoteEff & !ctrl_q.stopMode;
      end
   end

   assign controlOutputLevel = level_q;
   assign pidStartLevel      = pidStart_q;
   assign pidLoad            = pidLoad_q;
   assign valveTargetLevel   = valve_q;
   assign openSideDrive      = openDrv_q;
   assign closeSideDrive     = closeDrv_q;
   assign openSideLamp       = openDrv_q;
   assign closeSideLamp      = closeDrv_q;
   assign levelDisplayHide   = hide_q;
   assign handOperationLamp  = manLamp_q;
   assign farSourceLamp      = remLamp_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_lock_manual: assert property (
      amLocked && !wrCtrl |=> $stable(ctrl_q.reqAuto))
      else $error("key changed auto request while locked");
   chk_lock_local: assert property (
      rlLocked && !wrCtrl |=> $stable(ctrl_q.reqRemote))
      else $error("key changed remote request while locked");
   chk_bumpless_entry: assert property (
      enterMan && ctrl_q.bumpless && !wrCtrl
      |=> manual_q == $past(autoLevel) &&
          controlOutputLevel == $past(autoLevel))
      else $error("bumpless entry lost auto level");
   chk_pid_start: assert property (
      leaveMan |=> pidLoad && pidStartLevel == $past(manual_q)
      ##1 !pidLoad)
      else $error("pid start level wrong");
   chk_contact_wait: assert property (
      g_flt[0].eff_q != $past(g_flt[0].eff_q)
      |-> $past(g_flt[0].cnt_q) == 16'h0000 && $past(sampleTick))
      else $error("contact applied before delay");
   chk_lamp_manual: assert property (
      ##1 handOperationLamp == $past(!autoEff))
      else $error("manual lamp mismatch");
   chk_open_release: assert property (
      !keyUp |=> !openSideDrive && !openSideLamp)
      else $error("open drive stayed on after release");
   chk_close_release: assert property (
      !keyDown |=> !closeSideDrive && !closeSideLamp)
      else $error("close drive stayed on after release");
   chk_stop_dark: assert property (
      ctrl_q.stopMode |=> !farSourceLamp)
      else $error("remote lamp lit in stop");
   chk_type1_toggle: assert property (
      press[ams_pkg::KEY_RL] && !ctrl_q.keyType2 && !rlScr && !wrCtrl
      |=> $stable(ctrl_q.reqRemote))
      else $error("type 1 remote toggle acted");
   chk_remote_lamp: assert property (
      farSourceLamp |-> $past(remoteEff))
      else $error("remote lamp without remote mode");
   chk_step_up: assert property (
      adjOk && press[ams_pkg::KEY_UP] && !keys[ams_pkg::KEY_DN] &&
      !enterMan && manual_q < ams_pkg::LEVEL_MAX
      |=> manual_q > $past(manual_q))
      else $error("up press did not raise level");
   chk_step_down: assert property (
      adjOk && press[ams_pkg::KEY_DN] && !keys[ams_pkg::KEY_UP] &&
      !enterMan && manual_q != 16'h0000
      |=> manual_q < $past(manual_q))
      else $error("down press did not lower level");
endmodule // ams_mode_select

/* tb/ams_panel_model.sv */
// operator panel and contact model driving the mode selector
`timescale 1ns/1ps
module ams_panel_model (
   input  wire logic       core_clk,
   input  wire logic [4:0] keyCmd,
   input  wire logic [2:0] contactCmd,
   output      logic [4:0] keys,
   output      logic [2:0] contacts
);
   initial begin
      keys     = 5'h00;
      contacts = 3'h7;
   end
   // panel scan: levels move just after an edge and then stand
   always @(posedge core_clk) begin
      keys     <= keyCmd;
      contacts <= contactCmd;
   end
endmodule // ams_panel_model

/* tb/ams_mode_select_bench.sv */
// self-checking bench of the mode selector
`timescale 1ns/1ps
module ams_mode_select_bench;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [4:0]  keyCmd, keys;
   logic [2:0]  contactCmd, contacts;
   logic [15:0] autoLevel, controlOutputLevel, pidStartLevel;
   logic [15:0] valveTargetLevel, l0;
   logic        pidLoad, openSideDrive, closeSideDrive, openSideLamp;
   logic        closeSideLamp, levelDisplayHide, handOperationLamp;
   logic        farSourceLamp, er;
   int          failCount, samplesChecked, early;
   localparam int UP = ams_pkg::KEY_UP;
   localparam int DN = ams_pkg::KEY_DN;
   localparam int SH = ams_pkg::KEY_SH;
   localparam int AM = ams_pkg::KEY_AM;
   localparam int RL = ams_pkg::KEY_RL;

   ams_panel_model ams_panel_model_i (.core_clk(core_clk), .keyCmd(keyCmd),
      .contactCmd(contactCmd), .keys(keys), .contacts(contacts));
   ams_mode_select #(.TICK_CYCLES(4)) ams_mode_select_i (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .keyUp(keys[UP]),
      .keyDown(keys[DN]), .keyShift(keys[SH]), .keyAmToggle(keys[AM]),
      .keyRlToggle(keys[RL]), .contactInputFive(contacts[0]),
      .contactInputSix(contacts[1]), .contactInputSeven(contacts[2]),
      .autoLevel(autoLevel), .controlOutputLevel(controlOutputLevel),
      .pidStartLevel(pidStartLevel), .pidLoad(pidLoad),
      .valveTargetLevel(valveTargetLevel), .openSideDrive(openSideDrive),
      .closeSideDrive(closeSideDrive), .openSideLamp(openSideLamp),
      .closeSideLamp(closeSideLamp), .levelDisplayHide(levelDisplayHide),
      .handOperationLamp(handOperationLamp), .farSourceLamp(farSourceLamp));

   always #25 core_clk = ~core_clk;

   task automatic final_report();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      d  = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         check(32'(pready), 32'h0000_0001);
         final_report();
      end
   endtask

   task automatic key(input int k, input logic v);
      @(posedge core_clk);
      keyCmd[k] <= v;
   endtask

   // one short press, then settle past the sampling edge
   task automatic tap(input int k);
      key(k, 1'b1);
      key(k, 1'b0);
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   task automatic waitSig(input int s, input logic v, input int lim);
      logic x;
      for (int n = 0; n < lim; n++) begin
         @(posedge core_clk);
         #1;
         x = s == 0 ? handOperationLamp : s == 1 ? farSourceLamp : pidLoad;
         if (x === v) return;
      end
      check(32'(x), 32'(v));
      final_report();
   endtask

   task automatic holdShift(input logic expMenu);
      key(SH, 1'b1);
      repeat (7900) @(posedge core_clk);
      apb(1'b0, ams_pkg::OFF_STATUS, 32'h0000_0000);
      check(32'(d[7]), 32'(!expMenu));
      repeat (120) @(posedge core_clk);
      key(SH, 1'b0);
      apb(1'b0, ams_pkg::OFF_STATUS, 32'h0000_0000);
      check(32'(d[7]), 32'(expMenu));
   endtask

   task automatic sc_reset();
      apb(1'b0, ams_pkg::OFF_CTRL, 32'h0000_0000);
      check(d, 32'h0000_0005);
      apb(1'b0, ams_pkg::OFF_SAMPLE, 32'h0000_0000);
      check(d, 32'h0000_0064);
      apb(1'b0, ams_pkg::OFF_STATUS, 32'h0000_0000);
      check(32'({d[2], d[0]}), 32'h0000_0001);
      apb(1'b1, 12'h010, 32'h0000_0000);
      check(32'(er), 32'h0000_0001);
   endtask

   task automatic sc_handover();
      tap(AM);
      waitSig(0, 1'b1, 20);
      check(32'(controlOutputLevel), 32'h0000_0123);
      tap(UP);
      check(32'(controlOutputLevel), 32'h0000_0124);
      key(AM, 1'b1);
      waitSig(2, 1'b1, 20);
      check(32'(pidStartLevel), 32'h0000_0124);
      key(AM, 1'b0);
      waitSig(0, 1'b0, 20);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0001);
      autoLevel <= 16'h0200;
      tap(AM);
      waitSig(0, 1'b1, 20);
      check(32'(controlOutputLevel), 32'h0000_0124);
      key(UP, 1'b1);
      repeat (4800) @(posedge core_clk);
      #1;
      l0 = controlOutputLevel;
      repeat (400) @(posedge core_clk);
      #1;
      check(32'(controlOutputLevel - l0), 32'h0000_000A);
      key(UP, 1'b0);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0005);
   endtask

   task automatic sc_menu();
      holdShift(1'b1);
      tap(UP);
      check(32'(handOperationLamp), 32'h0000_0001);
      tap(DN);
      check(32'(handOperationLamp), 32'h0000_0000);
      tap(SH);
      tap(UP);
      check(32'(farSourceLamp), 32'h0000_0001);
      tap(DN);
      check(32'(farSourceLamp), 32'h0000_0000);
      holdShift(1'b0);
   endtask

   task automatic sc_contact_am();
      apb(1'b1, ams_pkg::OFF_SAMPLE, 32'h0000_000A);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0085);
      repeat (100) @(posedge core_clk);
      contactCmd[0] <= 1'b0;
      early = 0;
      repeat (780) begin
         @(posedge core_clk);
         #1;
         if (handOperationLamp !== 1'b0) early++;
      end
      check(32'(early), 32'h0000_0000);
      waitSig(0, 1'b1, 120);
      apb(1'b0, ams_pkg::OFF_STATUS, 32'h0000_0000);
      check(32'(d[5]), 32'h0000_0001);
      tap(AM);
      apb(1'b0, ams_pkg::OFF_CTRL, 32'h0000_0000);
      check(32'({d[0], handOperationLamp}), 32'h0000_0003);
      contactCmd[0] <= 1'b1;
      waitSig(0, 1'b0, 1000);
   endtask

   task automatic sc_contact_rl();
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0407);
      waitSig(1, 1'b1, 10);
      tap(RL);
      check(32'(farSourceLamp), 32'h0000_0001);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_040F);
      tap(RL);
      check(32'(farSourceLamp), 32'h0000_0000);
      tap(RL);
      check(32'(farSourceLamp), 32'h0000_0001);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_044F);
      waitSig(1, 1'b0, 4);
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_040F);
      contactCmd[1] <= 1'b0;
      waitSig(1, 1'b0, 1000);
      tap(RL);
      apb(1'b0, ams_pkg::OFF_CTRL, 32'h0000_0000);
      check(32'(d[1]), 32'h0000_0001);
      contactCmd[1] <= 1'b1;
      waitSig(1, 1'b1, 1000);
   endtask

   task automatic sc_valve();
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0024);
      waitSig(0, 1'b1, 10);
      for (int k = UP; k <= DN; k++) begin
         key(k, 1'b1);
         repeat (4) @(posedge core_clk);
         #1;
         check(32'({openSideDrive, openSideLamp, closeSideDrive,
            closeSideLamp, levelDisplayHide}),
            k == UP ? 32'h0000_0019 : 32'h0000_0007);
         key(k, 1'b0);
         repeat (4) @(posedge core_clk);
         #1;
         check(32'({openSideDrive, closeSideDrive, levelDisplayHide}),
            32'h0000_0001);
      end
      apb(1'b1, ams_pkg::OFF_CTRL, 32'h0000_0034);
      tap(UP);
      check(32'(valveTargetLevel), 32'h0000_0201);
      tap(DN);
      check(32'(valveTargetLevel), 32'h0000_0200);
   endtask

   initial begin
      core_clk   = 1'b0;
      rst_n      = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0000_0000;
      keyCmd     = 5'h00;
      contactCmd = 3'h7;
      autoLevel  = 16'h0123;
      failCount  = 0;
      samplesChecked = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      sc_reset();
      sc_handover();
      sc_menu();
      sc_contact_am();
      sc_contact_rl();
      sc_valve();
      final_report();
   end
endmodule // ams_mode_select_bench
